/* i2cp_pkg.sv */
`default_nettype none
package i2cp_pkg;
  // control/status register bit positions
  localparam int CSR_PIN = 7;  // pending-not flag, low while a byte waits
  localparam int CSR_ESO = 6;  // serial enable bit
  localparam int CSR_ES1 = 5;  // register select bit one
  localparam int CSR_ES2 = 4;  // register select bit two
  localparam int CSR_ENI = 3;  // interrupt enable flag

  // reset values: every flag clear except pending-not
  localparam logic [7:0] CSR_RST = 8'h80;
  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] CLK_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;

  // indirect register codes {serial enable, select one, select two}
  localparam logic [2:0] SEL_OWN  = 3'h0;
  localparam logic [2:0] SEL_CLK  = 3'h1;
  localparam logic [2:0] SEL_VEC  = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h4;

  // host bus styles
  localparam logic MODE_SEP = 1'b0;  // separate read and write strobes
  localparam logic MODE_HS  = 1'b1;  // asynchronous handshake, r/w plus ack

  // strobe output pulse timing
  localparam int CLK_NS     = 20;
  localparam int STROBE_NS  = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_W   = 4;

  // host access sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } i2cp_state_t;
endpackage
`default_nettype wire

/* i2cp_pin_if.sv */
`default_nettype none
interface i2cp_pin_if;
  logic long_dist;  // four-wire long-distance mode
  logic sda_drive;  // engine pulls data low
  logic scl_drive;  // engine pulls clock low
  logic irq_req;    // interrupt request from the core
  logic sda_level;  // sensed serial data
  logic scl_level;  // sensed serial clock
  logic irq_ack_in_n;     // interrupt acknowledge, active low

  modport core (output long_dist, sda_drive, scl_drive, irq_req,
                input  sda_level, scl_level, irq_ack_in_n);
  modport pins (input  long_dist, sda_drive, scl_drive, irq_req,
                output sda_level, scl_level, irq_ack_in_n);
endinterface
`default_nettype wire

/* i2cp_pin_mux.sv */
`default_nettype none
module i2cp_pin_mux
  import i2cp_pkg::*;
(
  // clock and reset
  input  wire logic  sys_clk_in,
  input  wire logic  rst_n_in,
  // core side
  i2cp_pin_if.pins   pif,
  // pins
  input  wire logic  sda_pin_in,
  output var  logic  sda_pin_out,
  output var  logic  sda_pin_oe_out,
  input  wire logic  scl_pin_in,
  output var  logic  scl_pin_oe_out,
  input  wire logic  irq_ack_pin_in,
  output var  logic  irq_pin_out,
  output var  logic  irq_pin_oe_out
);
  logic sda_o_nxt, sda_oe_nxt, scl_oe_nxt, irq_o_nxt, irq_oe_nxt;

  // sensed levels; in long mode data comes in on the acknowledge pin
  assign pif.sda_level = pif.long_dist ? irq_ack_pin_in : sda_pin_in;
  assign pif.scl_level = scl_pin_in;
  assign pif.irq_ack_in_n    = pif.long_dist ? 1'b1 : irq_ack_pin_in;

  always_comb begin
    sda_o_nxt  = 1'b0;
    sda_oe_nxt = pif.sda_drive;
    scl_oe_nxt = pif.scl_drive;
    irq_o_nxt  = 1'b0;
    irq_oe_nxt = pif.irq_req;
    if (pif.long_dist) begin
      sda_o_nxt  = ~pif.sda_drive;  // push-pull, line drivers follow
      sda_oe_nxt = 1'b1;
      scl_oe_nxt = 1'b0;            // clock pin is input only
      irq_o_nxt  = ~pif.scl_drive;
      irq_oe_nxt = 1'b1;
    end
  end

  // pins come from flops so no glitch reaches the wires
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_pin_out    <= 1'b0;
      sda_pin_oe_out <= 1'b0;
      scl_pin_oe_out <= 1'b0;
      irq_pin_out    <= 1'b0;
      irq_pin_oe_out <= 1'b0;
    end else begin
      sda_pin_out    <= sda_o_nxt;
      sda_pin_oe_out <= sda_oe_nxt;
      scl_pin_oe_out <= scl_oe_nxt;
      irq_pin_out    <= irq_o_nxt;
      irq_pin_oe_out <= irq_oe_nxt;
    end
  end

  a_long_pin_map: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    pif.long_dist |=> sda_pin_oe_out && irq_pin_oe_out && !scl_pin_oe_out)
    else $error("long mode pin directions wrong");
endmodule
`default_nettype wire

/* i2cp_host_port.sv */
// How it works
// - Outside long-distance mode, acknowledge with interrupts enabled puts the vector register on the data bus.
// - Outside long-distance mode, interrupt pin drives only while the interrupt enable flag is set.
// - With interrupts enabled, interrupt asserts whenever pending-not is clear.
// - Each completed byte on the serial bus clears pending-not.
// - Register select high addresses the control/status register.
// - Register select low picks a register by serial enable and two select bits.
// - Reset clears every flag but sets pending-not.
// - Read pin is read strobe, or open-drain transfer acknowledge in handshake mode.
// - Long-distance mode turns four pins into unidirectional serial lines.
// - Reset pin can also be driven by the device as a strobe.
// - Long-distance transfers are controlled as in two-wire mode.
`default_nettype none
module i2cp_host_port
  import i2cp_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // configuration
  input  wire logic        bus_mode_in,
  input  wire logic        long_dist_in,
  // host bus
  input  wire logic        cs_n_in,
  input  wire logic        register_select_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [7:0]  host_data_in,
  output var  logic [7:0]  host_data_out,
  output var  logic        host_data_oe_out,
  output var  logic        transfer_ack_oe_out,
  // status
  output var  logic [7:0]  ctrl_status_out,
  // byte engine side
  input  wire logic        byte_done_in,
  input  wire logic        rx_load_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        eng_sda_drive_in,
  input  wire logic        eng_scl_drive_in,
  output var  logic        eng_sda_level_out,
  output var  logic        eng_scl_level_out,
  output var  logic [7:0]  tx_byte_out,
  output var  logic        tx_load_out,
  output var  logic [7:0]  own_addr_out,
  output var  logic [7:0]  clk_cfg_out,
  // strobe on the reset pin
  input  wire logic        strobe_req_in,
  output var  logic        strobe_oe_out,
  // serial pins
  input  wire logic        sda_pin_in,
  output var  logic        sda_pin_out,
  output var  logic        sda_pin_oe_out,
  input  wire logic        scl_pin_in,
  output var  logic        scl_pin_oe_out,
  input  wire logic        irq_ack_in,
  output var  logic        irq_pin_out,
  output var  logic        irq_pin_oe_out
);
  // counter must fit its register and last at least one cycle
  if (STROBE_LEN < 1 || STROBE_LEN > 15) begin : g_bad_len
    $error("STROBE_LEN out of range");
  end

  i2cp_pin_if pif ();

  i2cp_pin_mux u_mux (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .pif            (pif.pins),
    .sda_pin_in     (sda_pin_in),
    .sda_pin_out    (sda_pin_out),
    .sda_pin_oe_out (sda_pin_oe_out),
    .scl_pin_in     (scl_pin_in),
    .scl_pin_oe_out (scl_pin_oe_out),
    .irq_ack_pin_in (irq_ack_in),
    .irq_pin_out    (irq_pin_out),
    .irq_pin_oe_out (irq_pin_oe_out)
  );

  // engine and mode go straight to the pin mux
  assign pif.long_dist = long_dist_in;
  assign pif.sda_drive = eng_sda_drive_in;
  assign pif.scl_drive = eng_scl_drive_in;

  i2cp_state_t      state_r, state_nxt;
  logic             rdacc_r, rdacc_nxt;
  logic [7:0]       ctrl_status_reg, csr_nxt;
  logic [7:0]       irq_vector_reg, vec_nxt;
  logic [7:0]       own_r, own_nxt, clk_r, clk_nxt, dat_r, dat_nxt;
  logic [7:0]       dout_nxt;
  logic             doe_nxt, ack_nxt, load_nxt, irq_r, irq_nxt;
  logic [STROBE_W-1:0] strobe_cnt_r, strobe_cnt_nxt;
  logic             start, is_rd, done, take;
  logic [2:0]       sel;
  logic [7:0]       rd_mux;
  logic             irq_enable_flag, serial_enable_bit;
  logic             reg_select_bit_one, reg_select_bit_two;

  assign irq_enable_flag    = ctrl_status_reg[CSR_ENI];
  assign serial_enable_bit  = ctrl_status_reg[CSR_ESO];
  assign reg_select_bit_one = ctrl_status_reg[CSR_ES1];
  assign reg_select_bit_two = ctrl_status_reg[CSR_ES2];
  assign sel = {serial_enable_bit, reg_select_bit_one, reg_select_bit_two};

  // pin roles follow the bus style
  // write pin is strobe or direction
  always_comb begin
    if (bus_mode_in == MODE_HS) begin
      start = ~cs_n_in;
      is_rd = wr_n_in;  // high means read
      done  = cs_n_in;
    end else begin
      start = ~cs_n_in & (~rd_n_in | ~wr_n_in);
      is_rd = ~rd_n_in; // both low counts as a read
      done  = cs_n_in | (rd_n_in & wr_n_in);
    end
  end
  assign take = (state_r == ST_IDLE) & start;

  // select low decodes the indirect register
  always_comb begin
    if (register_select_in) begin
      rd_mux = ctrl_status_reg;
    end else begin
      case (sel)
        SEL_OWN:  rd_mux = own_r;
        SEL_CLK:  rd_mux = clk_r;
        SEL_VEC:  rd_mux = irq_vector_reg;
        SEL_DATA: rd_mux = dat_r;
        default:  rd_mux = 8'h00;
      endcase
    end
  end

  // access sequencer and bus drive
  always_comb begin
    state_nxt = state_r;
    rdacc_nxt = rdacc_r;
    dout_nxt  = host_data_out;
    doe_nxt   = 1'b0;
    ack_nxt   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_BUSY;
          rdacc_nxt = is_rd;
          doe_nxt   = is_rd;
          ack_nxt   = (bus_mode_in == MODE_HS);
          if (is_rd) begin
            dout_nxt = rd_mux;
          end
        end else if (!pif.irq_ack_in_n && irq_enable_flag) begin
          doe_nxt  = 1'b1;
          dout_nxt = irq_vector_reg;
        end
      end
      ST_BUSY: begin
        if (done) begin
          state_nxt = ST_IDLE;
        end else begin
          doe_nxt = rdacc_r;  // read data holds until the strobe ends
          ack_nxt = (bus_mode_in == MODE_HS);
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r             <= ST_IDLE;
      rdacc_r             <= 1'b0;
      host_data_out       <= 8'h00;
      host_data_oe_out    <= 1'b0;
      transfer_ack_oe_out <= 1'b0;
    end else begin
      state_r             <= state_nxt;
      rdacc_r             <= rdacc_nxt;
      host_data_out       <= dout_nxt;
      host_data_oe_out    <= doe_nxt;
      transfer_ack_oe_out <= ack_nxt;
    end
  end

  // register file; a host data access sets pending-not again
  always_comb begin
    csr_nxt  = ctrl_status_reg;
    vec_nxt  = irq_vector_reg;
    own_nxt  = own_r;
    clk_nxt  = clk_r;
    dat_nxt  = dat_r;
    load_nxt = 1'b0;
    if (take && !is_rd) begin
      if (register_select_in) begin
        csr_nxt = host_data_in;
      end else begin
        case (sel)
          SEL_OWN:  own_nxt = host_data_in;
          SEL_CLK:  clk_nxt = host_data_in;
          SEL_VEC:  vec_nxt = host_data_in;
          SEL_DATA: begin
            dat_nxt          = host_data_in;
            load_nxt         = 1'b1;
            csr_nxt[CSR_PIN] = 1'b1;
          end
          default:  csr_nxt = ctrl_status_reg;  // unused codes ignore writes
        endcase
      end
    end
    if (take && is_rd && !register_select_in && sel == SEL_DATA) begin
      csr_nxt[CSR_PIN] = 1'b1;
    end
    if (rx_load_in) begin
      dat_nxt = rx_byte_in;
    end
    // byte complete clears pending-not, beating a host set
    if (byte_done_in) begin
      csr_nxt[CSR_PIN] = 1'b0;
    end
    irq_nxt = csr_nxt[CSR_ENI] & ~csr_nxt[CSR_PIN];
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_status_reg <= CSR_RST;
      irq_vector_reg  <= VEC_RST;
      own_r           <= OWN_RST;
      clk_r           <= CLK_RST;
      dat_r           <= DAT_RST;
      tx_load_out     <= 1'b0;
      irq_r           <= 1'b0;
    end else begin
      ctrl_status_reg <= csr_nxt;
      irq_vector_reg  <= vec_nxt;
      own_r           <= own_nxt;
      clk_r           <= clk_nxt;
      dat_r           <= dat_nxt;
      tx_load_out     <= load_nxt;
      irq_r           <= irq_nxt;
    end
  end

  // request leaves from the next value so the pin flop lines up with the enable flag
  assign pif.irq_req = irq_nxt;

  // plain copies so every output leaves from a flop
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_status_out   <= CSR_RST;
      tx_byte_out       <= DAT_RST;
      own_addr_out      <= OWN_RST;
      clk_cfg_out       <= CLK_RST;
      eng_sda_level_out <= 1'b1;
      eng_scl_level_out <= 1'b1;
    end else begin
      ctrl_status_out   <= csr_nxt;
      tx_byte_out       <= dat_nxt;
      own_addr_out      <= own_nxt;
      clk_cfg_out       <= clk_nxt;
      eng_sda_level_out <= pif.sda_level;
      eng_scl_level_out <= pif.scl_level;
    end
  end

  // fixed-length strobe on the reset pin
  // retrigger is ignored so the pulse width never stretches;
  // the board must keep this pulse away from the device's own reset
  always_comb begin
    strobe_cnt_nxt = strobe_cnt_r;
    if (strobe_cnt_r != '0) begin
      strobe_cnt_nxt = strobe_cnt_r - 1'b1;
    end else if (strobe_req_in) begin
      strobe_cnt_nxt = STROBE_W'(STROBE_LEN);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_cnt_r  <= '0;
      strobe_oe_out <= 1'b0;
    end else begin
      strobe_cnt_r  <= strobe_cnt_nxt;
      strobe_oe_out <= (strobe_cnt_nxt != '0);
    end
  end

  a_vector_on_ack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_r == ST_IDLE && !start && !pif.irq_ack_in_n && irq_enable_flag)
      |=> host_data_oe_out && host_data_out == $past(irq_vector_reg))
    else $error("vector not driven on acknowledge");

  a_irq_disabled: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !irq_enable_flag && !$past(pif.long_dist) |-> !irq_pin_oe_out)
    else $error("interrupt driven while disabled");

  a_irq_on_byte: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    byte_done_in && irq_enable_flag && !(take && !is_rd && register_select_in)
      |=> irq_r && irq_pin_oe_out)
    else $error("interrupt missing after byte");

  a_byte_clears_pin: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    byte_done_in |=> !ctrl_status_reg[CSR_PIN] && !ctrl_status_out[CSR_PIN])
    else $error("pending-not not cleared");

  a_csr_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    take && is_rd && register_select_in
      |=> host_data_oe_out && host_data_out == $past(ctrl_status_reg))
    else $error("control/status read wrong");

  a_indirect_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    take && is_rd && !register_select_in && sel == SEL_VEC
      |=> host_data_out == $past(irq_vector_reg))
    else $error("indirect read wrong");

  a_reset_flags: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> ctrl_status_reg == CSR_RST && !irq_r)
    else $error("reset state wrong");

  a_handshake_ack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    take && bus_mode_in == MODE_HS && !cs_n_in ##1 !cs_n_in
      |=> transfer_ack_oe_out && $past(transfer_ack_oe_out))
    else $error("transfer acknowledge missing");

  a_strobe_width: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    strobe_req_in && strobe_cnt_r == '0 && STROBE_LEN == 5
      |=> strobe_oe_out [*5] ##1 !strobe_oe_out)
    else $error("strobe width wrong");
endmodule
`default_nettype wire

/* i2cp_host_model.sv */
`default_nettype none
module i2cp_host_model (
  // clock and device answers
  input  wire logic       clk_in,
  input  wire logic       hs_mode_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  input  wire logic       ack_oe_in,
  // host strobes and data
  output var  logic       cs_n_out,
  output var  logic       rs_out,
  output var  logic       rd_n_out,
  output var  logic       wr_n_out,
  output var  logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_ok;  // answer seen on the last access

  // bus idles with strobes released
  initial begin
    cs_n_out = 1'b1;
    rs_out   = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    data_out = 8'h00;
    last_ok  = 1'b0;
  end

  // one byte access; a read or a handshake cycle waits for the answer, bounded
  task automatic access(input logic rs, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdat);
    int n;
    rdat = 8'h00;
    n = 0;
    last_ok = 1'b0;
    @(posedge clk_in);
    #2;
    cs_n_out = 1'b0;
    rs_out   = rs;
    data_out = wd;
    if (hs_mode_in) wr_n_out = rd;
    else if (rd) rd_n_out = 1'b0;
    else wr_n_out = 1'b0;
    if (hs_mode_in || rd) begin
      do begin
        @(posedge clk_in);
        #2;
        n++;
      end while (!(hs_mode_in ? ack_oe_in : dev_oe_in) && n < 8);
      last_ok = hs_mode_in ? ack_oe_in : dev_oe_in;
      rdat = dev_data_in;
      // hold the request through the edge that samples the answer
      @(posedge clk_in);
      #2;
    end else begin
      @(posedge clk_in);
      #2;
      last_ok = 1'b1;
    end
    // released data shows the inverse, never a stale copy
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    data_out = ~wd;
    repeat (2) @(posedge clk_in);
    #2;
  endtask
endmodule
`default_nettype wire

/* i2c_controller_host_port_tb.sv */
`default_nettype none
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module i2c_controller_host_port_tb
  import i2cp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLEN = 5;  // default width, so the fixed-width check is exercised
  logic       clk, rst_n, bus_mode, long_dist, cs_n, rs, rd_n, wr_n, byte_done;
  logic       sda_drv, scl_drv, strobe_req, irq_ack, scl_far, sda_pin, scl_pin;
  logic       hdat_oe, ack_oe, sda_lvl, scl_lvl, strobe_oe;
  logic       sda_out, sda_oe, scl_oe, irq_out, irq_oe, rx_load, tx_load;
  logic [7:0] hdat_in, hdat_out, csr, tx_byte, own_addr, clk_cfg, rdat, rx_byte;
  int         failures, n_tests, n_loads;

  // open-drain serial lines with pull-ups
  assign sda_pin = sda_oe ? sda_out : 1'b1;
  assign scl_pin = scl_oe ? 1'b0 : scl_far;

  i2cp_host_port #(.STROBE_LEN(SLEN)) DUT (
    .sys_clk_in(clk), .rst_n_in(rst_n), .bus_mode_in(bus_mode), .long_dist_in(long_dist),
    .cs_n_in(cs_n), .register_select_in(rs), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .host_data_in(hdat_in), .host_data_out(hdat_out), .host_data_oe_out(hdat_oe),
    .transfer_ack_oe_out(ack_oe), .ctrl_status_out(csr), .byte_done_in(byte_done),
    .rx_load_in(rx_load), .rx_byte_in(rx_byte), .eng_sda_drive_in(sda_drv),
    .eng_scl_drive_in(scl_drv), .eng_sda_level_out(sda_lvl), .eng_scl_level_out(scl_lvl),
    .tx_byte_out(tx_byte), .tx_load_out(tx_load), .own_addr_out(own_addr), .clk_cfg_out(clk_cfg),
    .strobe_req_in(strobe_req), .strobe_oe_out(strobe_oe), .sda_pin_in(sda_pin),
    .sda_pin_out(sda_out), .sda_pin_oe_out(sda_oe), .scl_pin_in(scl_pin),
    .scl_pin_oe_out(scl_oe), .irq_ack_in(irq_ack), .irq_pin_out(irq_out),
    .irq_pin_oe_out(irq_oe));

  i2cp_host_model HOST (
    .clk_in(clk), .hs_mode_in(bus_mode), .dev_data_in(hdat_out), .dev_oe_in(hdat_oe),
    .ack_oe_in(ack_oe), .cs_n_out(cs_n), .rs_out(rs), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .data_out(hdat_in));

  // count load pulses to the engine; one cycle is too short to poll from a task
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) n_loads <= 0;
    else if (tx_load) n_loads <= n_loads + 1;
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // wait edges, then step past them so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic r, input logic [7:0] d);
    logic [7:0] x;
    HOST.access(r, 1'b0, d, x);
  endtask
  task automatic done_pulse();
    cyc(1);
    byte_done = 1'b1;
    cyc(1);
    byte_done = 1'b0;
    cyc(2);
  endtask

  // reset in mid-run must win asynchronously over any flag state
  task automatic t_reset();
    rst_n = 1'b0;
    #5;
    `CHK(csr, CSR_RST)
    `CHK({hdat_oe, ack_oe, irq_oe, strobe_oe}, 4'h0)
    cyc(2);
    rst_n = 1'b1;
  endtask

  task automatic t_regs();
    logic [2:0] codes [4] = '{SEL_OWN, SEL_CLK, SEL_VEC, 3'h7};
    wr(1'b1, 8'h8f);
    `CHK(csr, 8'h8f)
    HOST.access(1'b1, 1'b1, 8'h00, rdat);
    `CHK(rdat, 8'h8f)
    // unused select code reads as zero
    for (int i = 0; i < 4; i++) begin
      wr(1'b1, {1'b1, codes[i], 4'h0});
      wr(1'b0, 8'(8'h31 + i));
      HOST.access(1'b0, 1'b1, 8'h00, rdat);
      `CHK(rdat, (i == 3) ? 8'h00 : 8'(8'h31 + i))
    end
    `CHK({own_addr, clk_cfg}, 16'h3132)
    wr(1'b1, {1'b1, SEL_DATA, 4'h0});
    wr(1'b0, 8'ha5);
    `CHK({tx_byte, n_loads[3:0]}, 12'ha51)
    // received byte lands with the byte-done event; reading it sets pending-not again
    rx_byte = 8'h5c;
    {rx_load, byte_done} = 2'b11;
    cyc(1);
    {rx_load, byte_done} = 2'b00;
    `CHK(csr[CSR_PIN], 1'b0)
    HOST.access(1'b0, 1'b1, 8'h00, rdat);
    `CHK({csr[CSR_PIN], rdat}, 9'h15c)
  endtask

  task automatic t_irq();
    int n;
    wr(1'b1, 8'h80);
    done_pulse();
    `CHK(csr[CSR_PIN], 1'b0)
    `CHK(irq_oe, 1'b0)
    wr(1'b1, 8'h88);
    cyc(2);
    `CHK(irq_oe, 1'b0)
    done_pulse();
    `CHK({irq_oe, irq_out}, 2'b10)
    irq_ack = 1'b0;
    n = 0;
    while (hdat_oe !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    `CHK({hdat_oe, hdat_out}, 9'h133)
    irq_ack = 1'b1;
    cyc(3);
    `CHK(hdat_oe, 1'b0)
    t_reset();
  endtask

  task automatic t_handshake();
    bus_mode = 1'b1;
    wr(1'b1, 8'h84);
    HOST.access(1'b1, 1'b1, 8'h00, rdat);
    `CHK({HOST.last_ok, rdat}, 9'h184)
    `CHK(ack_oe, 1'b0)
    bus_mode = 1'b0;
  endtask

  task automatic t_pins();
    // interrupts enabled, so an ignored acknowledge in long mode is visible
    wr(1'b1, 8'h88);
    sda_drv = 1'b1;
    scl_drv = 1'b1;
    cyc(3);
    `CHK({sda_oe, sda_out, scl_oe, scl_lvl}, 4'b1010)
    long_dist = 1'b1;
    sda_drv = 1'b0;
    irq_ack = 1'b0;
    cyc(3);
    `CHK({sda_oe, sda_out, scl_oe, irq_oe, irq_out}, 5'b11010)
    `CHK({sda_lvl, scl_lvl, hdat_oe}, 3'b010)
    long_dist = 1'b0;
    scl_drv = 1'b0;
    irq_ack = 1'b1;
    cyc(3);
  endtask

  task automatic t_strobe();
    int n;
    n = 0;
    strobe_req = 1'b1;
    cyc(1);
    strobe_req = 1'b0;
    repeat (SLEN + 4) begin
      if (strobe_oe === 1'b1) n++;
      cyc(1);
    end
    `CHK(n, SLEN)
  endtask

  // a hang beyond a few thousand cycles counts against the run
  initial begin
    #100us;
    failures++;
    summarize();
  end

  initial begin
    {rst_n, bus_mode, long_dist, byte_done, sda_drv, scl_drv, strobe_req, rx_load} = 8'h00;
    rx_byte = 8'h00;
    {irq_ack, scl_far} = 2'b11;
    failures = 0;
    n_tests = 0;
    cyc(12);
    `CHK(csr, CSR_RST)
    rst_n = 1'b1;
    cyc(1);
    t_regs();
    t_irq();
    t_handshake();
    t_pins();
    t_strobe();
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
